// *** design/icd_readout.sv ***
// Operation
// - congruence class comes from effective address bits 19 to 26
// - way select 0 reads way A, 1 reads way B
// - word mode captures the word picked by address bits 27 to 29
// - tag mode captures tag and status instead of a word
// - every debug read replaces the 32-bit debug data register
// - word mode fills all 32 bits with the selected word
// - tag mode: tag bits 0-21, valid bit 27, replacement bit 31
// - valid flag reads 1 only for a valid selected line
// - replacement flag is per class: 0 way A LRU, 1 way B LRU
// - debug data is privileged read-only special register 979
// - after sync, register read returns latest debug read value
// - data-cache debug read uses same selections, result to a general register
`timescale 1ns/1ps
`default_nettype none
module icd_readout import icd_pkg::*; #(
  parameter int unsigned P_WORDS = ICD_WORDS,
  parameter int unsigned P_TAG_W = ICD_TAG_W
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire icd_req_t i_req,
  input wire icd_spr_t i_spr,
  input wire logic [32*P_WORDS-1:0] i_line_a,
  input wire logic [32*P_WORDS-1:0] i_line_b,
  input wire logic [P_TAG_W-1:0] i_tag_a,
  input wire logic [P_TAG_W-1:0] i_tag_b,
  input wire logic i_valid_a,
  input wire logic i_valid_b,
  input wire logic i_lru,
  output logic [7:0] o_class,
  output logic [31:0] o_icache_debug_data,
  output logic [31:0] o_spr_rdata,
  output logic o_spr_ack,
  output logic o_spr_priv_fault
);
  //////////////////////////////////////////////////////////////////////////////
  // field widths implied by the fixed positions in the package
  localparam int unsigned CLASS_W = ICD_EA_CLASS_HI - ICD_EA_CLASS_LO + 1;
  localparam int unsigned WORD_IDX_W = ICD_EA_WORD_HI - ICD_EA_WORD_LO + 1;
  localparam int unsigned TAG_ROOM = 32 - ICD_TAG_POS;

  // refuse geometries that the fixed address slices or the tag image cannot
  // serve: a mismatch would silently read the wrong word or clip the tag
  if (P_WORDS != (1 << WORD_IDX_W)) begin : g_bad_words
    $error("word count does not match the word index field");
  end
  if (P_TAG_W != TAG_ROOM) begin : g_bad_tag
    $error("tag width does not fill the tag field of the debug data");
  end
  if (ICD_SETS != (1 << CLASS_W)) begin : g_bad_sets
    $error("set count does not match the class index field");
  end

  //////////////////////////////////////////////////////////////////////////////
  // class index goes straight out so the array can present the addressed
  // set; the array read is combinational, a register here would cost a cycle
  wire logic [CLASS_W-1:0] class_idx = i_req.effective_address[ICD_EA_CLASS_HI:ICD_EA_CLASS_LO];
  assign o_class = class_idx;

  //////////////////////////////////////////////////////////////////////////////
  // request decode: one select line steers every per-way field; a data-side
  // debug read would reuse this decode and only change where the result goes
  wire logic pick_a = (i_req.way_sel == ICD_WAY_A);
  wire logic tag_mode = (i_req.tag_or_word_select != ICD_SEL_WORD);
  wire logic [WORD_IDX_W-1:0] word_idx = i_req.effective_address[ICD_EA_WORD_HI:ICD_EA_WORD_LO];
  // bit offset of the addressed word inside a line image
  wire logic [WORD_IDX_W+4:0] word_lsb = {word_idx, 5'h00};

  // way mux for the line, the tag and the valid flag of the addressed set
  wire logic [32*P_WORDS-1:0] sel_line = pick_a ? i_line_a : i_line_b;
  wire logic [31:0] sel_word = sel_line[word_lsb +: 32];
  wire logic [P_TAG_W-1:0] sel_tag = pick_a ? i_tag_a : i_tag_b;
  wire logic sel_valid = pick_a ? i_valid_a : i_valid_b;

  // tag image: each status field shifted into place; every position not
  // named stays zero so that software compares of the image are stable
  wire logic [31:0] tag_field = 32'(sel_tag) << ICD_TAG_POS;
  wire logic [31:0] valid_field = 32'(sel_valid) << ICD_VALID_POS;
  wire logic [31:0] lru_field = 32'(i_lru) << ICD_LRU_POS;
  wire logic [31:0] tag_image = tag_field | valid_field | lru_field;

  // the mode select hands over either the whole word or the tag image
  wire logic [31:0] capture = tag_mode ? tag_image : sel_word;

  //////////////////////////////////////////////////////////////////////////////
  // debug data register, reloaded by every debug read and held otherwise;
  // there is no write path, software can only copy it out; reset clears it
  // to zero, the same value an unanswered move returns
  logic [31:0] data_q;
  wire logic [31:0] data_d = i_req.valid ? capture : data_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      data_q <= ICD_DATA_RESET;
    end else begin
      data_q <= data_d;
    end
  end
  assign o_icache_debug_data = data_q;

  //////////////////////////////////////////////////////////////////////////////
  // special register port: read only and privileged; software puts a
  // context sync between the debug read and the move, so data_q has settled;
  // other register numbers belong to other decoders and get no answer here
  wire logic spr_hit = i_spr.valid && (i_spr.spr_num == ICD_SPR_DEBUG_DATA);
  wire logic spr_ok = spr_hit && i_spr.privileged;
  wire logic spr_refused = spr_hit && !i_spr.privileged;
  // an accepted read returns the register, anything else returns zero
  wire logic [31:0] rdata_d = spr_ok ? data_q : ICD_DATA_RESET;
  logic [31:0] rdata_q;
  logic ack_q;
  logic fault_q;

  // answer flops: one-cycle pulses, data non-zero only beside an acknowledge
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= ICD_DATA_RESET;
      ack_q <= 1'h0;
      fault_q <= 1'h0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= spr_ok;
      fault_q <= spr_refused;
    end
  end
  assign o_spr_rdata = rdata_q;
  assign o_spr_ack = ack_q;
  assign o_spr_priv_fault = fault_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks on the captured image, one cycle after the debug read

  // reserved positions of a tag image read zero
  reserved_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_req.valid && i_req.tag_or_word_select |=> (data_q[9:5] == 5'h00) && (data_q[3:1] == 3'h0))
    else $error("reserved bits not zero");

  // word mode returns the addressed word of the selected way
  word_capture_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_req.valid && !i_req.tag_or_word_select |=> data_q == $past(sel_word))
    else $error("word capture wrong");

  // way A word straight from the array port, independent of the mux
  way_a_word_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_req.valid && !i_req.tag_or_word_select && !i_req.way_sel
    |=> data_q == $past(i_line_a[word_lsb +: 32]))
    else $error("way A word wrong");

  // way B word straight from the array port
  way_b_word_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_req.valid && !i_req.tag_or_word_select && i_req.way_sel
    |=> data_q == $past(i_line_b[word_lsb +: 32]))
    else $error("way B word wrong");

  // tag field of a tag image matches the selected way
  tag_capture_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_req.valid && i_req.tag_or_word_select |=> data_q[31:10] == $past(sel_tag))
    else $error("tag capture wrong");

  // way A tag straight from the array port
  tag_way_a_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_req.valid && i_req.tag_or_word_select && !i_req.way_sel
    |=> data_q[31:10] == $past(i_tag_a))
    else $error("way A tag wrong");

  // way B tag straight from the array port
  tag_way_b_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_req.valid && i_req.tag_or_word_select && i_req.way_sel
    |=> data_q[31:10] == $past(i_tag_b))
    else $error("way B tag wrong");

  // valid flag of the selected line
  valid_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_req.valid && i_req.tag_or_word_select |=> data_q[4] == $past(sel_valid))
    else $error("valid flag wrong");

  // replacement flag of the class, shared by both ways
  lru_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_req.valid && i_req.tag_or_word_select |=> data_q[0] == $past(i_lru))
    else $error("lru flag wrong");

  // no debug read, no change
  hold_value_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !i_req.valid |=> $stable(data_q))
    else $error("debug data changed without read");

  //////////////////////////////////////////////////////////////////////////////
  // checks on the register port, one cycle after the move

  // an accepted move returns the register as it stood
  spr_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    spr_ok |=> o_spr_ack && o_spr_rdata == $past(data_q))
    else $error("register read mismatch");

  // with no debug read beside it, the move returns what the register shows
  spr_latest_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    spr_ok && !i_req.valid
    |=> o_spr_rdata == o_icache_debug_data)
    else $error("register read not latest");

  // an unprivileged move is refused with a fault and no acknowledge
  priv_check_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    spr_hit && !i_spr.privileged |=> o_spr_priv_fault && !o_spr_ack)
    else $error("unprivileged read not refused");

  // any other access leaves the port silent
  spr_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !spr_hit |=> !o_spr_ack && !o_spr_priv_fault && (o_spr_rdata == ICD_DATA_RESET))
    else $error("register port answered without a hit");

  //////////////////////////////////////////////////////////////////////////////
  // main scenarios that the bench should reach
  word_way_b_c: cover property (@(posedge i_ref_clk) i_req.valid && i_req.way_sel && !i_req.tag_or_word_select);
  tag_read_c: cover property (@(posedge i_ref_clk) i_req.valid && i_req.tag_or_word_select);
  tag_valid_b_c: cover property (@(posedge i_ref_clk) i_req.valid && tag_mode && !pick_a && sel_valid);
  read_then_move_c: cover property (@(posedge i_ref_clk) i_req.valid ##[1:4] spr_ok);
  refused_read_c: cover property (@(posedge i_ref_clk) spr_refused);
endmodule : icd_readout
`default_nettype wire

// *** design/icd_pkg.sv ***
package icd_pkg;
  // cache geometry
  localparam int unsigned ICD_SETS = 256;
  localparam int unsigned ICD_WORDS = 8;
  localparam int unsigned ICD_TAG_W = 22;
  // effective address field positions, big-endian bit 0 = msb of 32
  localparam int unsigned ICD_EA_CLASS_HI = 31 - 19;
  localparam int unsigned ICD_EA_CLASS_LO = 31 - 26;
  localparam int unsigned ICD_EA_WORD_HI = 31 - 27;
  localparam int unsigned ICD_EA_WORD_LO = 31 - 29;
  // debug data register number and field positions (little-endian index)
  localparam logic [9:0] ICD_SPR_DEBUG_DATA = 10'h3D3;
  localparam int unsigned ICD_TAG_POS = 31 - 21;
  localparam int unsigned ICD_VALID_POS = 31 - 27;
  localparam int unsigned ICD_LRU_POS = 31 - 31;
  localparam logic [31:0] ICD_DATA_RESET = 32'h0000_0000;
  // select field values
  localparam logic ICD_WAY_A = 1'b0;
  localparam logic ICD_SEL_WORD = 1'b0;

  // debug read request from the pipeline
  typedef struct packed {
    logic valid;
    logic [31:0] effective_address;
    logic way_sel;
    logic tag_or_word_select;
  } icd_req_t;

  // special register read request
  typedef struct packed {
    logic valid;
    logic [9:0] spr_num;
    logic privileged;
  } icd_spr_t;
endpackage : icd_pkg

// *** bench/icd_array_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// cache array stand-in: every class field is a fixed function of the class
// contents never move under a debug read: the far side keeps the array
// coherent with its store, flush and invalidate sequences
module icd_array_model import icd_pkg::*; (
  input wire logic [7:0] i_class,
  output logic [32*ICD_WORDS-1:0] o_line_a,
  output logic [32*ICD_WORDS-1:0] o_line_b,
  output logic [ICD_TAG_W-1:0] o_tag_a,
  output logic [ICD_TAG_W-1:0] o_tag_b,
  output logic o_valid_a,
  output logic o_valid_b,
  output logic o_lru
);
  // word n of a way reads class, way mark, n, inverted class
  for (genvar n = 0; n < ICD_WORDS; n++) begin : g_word
    assign o_line_a[n*32+:32] = {i_class, 8'h0A, 8'(n), ~i_class};
    assign o_line_b[n*32+:32] = {i_class, 8'h0B, 8'(n), ~i_class};
  end
  assign o_tag_a = {14'h0155, i_class};
  assign o_tag_b = {14'h2AAA, i_class};
  assign o_valid_a = i_class[0];
  assign o_valid_b = ~i_class[0];
  assign o_lru = i_class[1];
endmodule : icd_array_model
`default_nettype wire

// *** bench/tb_icd_readout.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_icd_readout import icd_pkg::*; ();
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  icd_req_t req = '0;
  icd_spr_t special_purpose_register = '0;
  logic [32*ICD_WORDS-1:0] la, lb;
  logic [ICD_TAG_W-1:0] ta, tg_b;
  logic va, vb, lru, ack, flt;
  logic [7:0] cls;
  logic [31:0] dbg, rd, last;
  int fails = 0;
  int cmp_count = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  icd_readout DUT (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req(req), .i_spr(special_purpose_register), .i_line_a(la),
    .i_line_b(lb), .i_tag_a(ta), .i_tag_b(tg_b), .i_valid_a(va), .i_valid_b(vb), .i_lru(lru), .o_class(cls),
    .o_icache_debug_data(dbg), .o_spr_rdata(rd), .o_spr_ack(ack), .o_spr_priv_fault(flt));
  icd_array_model MDL (.i_class(cls), .o_line_a(la), .o_line_b(lb), .o_tag_a(ta), .o_tag_b(tg_b),
    .o_valid_a(va), .o_valid_b(vb), .o_lru(lru));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // back-to-back debug reads over both ways, valid and lru values
  task automatic t_read(input logic sel);
    logic [7:0] c;
    logic [2:0] n;
    logic w;
    logic [7:0] pc;
    pc = 8'h00;
    for (int i = 0; i <= 4; i++) begin
      @(negedge i_ref_clk);
      if (i > 0) check(dbg, last);
      if (i > 0) check({24'h00_0000, cls}, {24'h00_0000, pc});
      c = 8'h3C + 8'(i) * 8'h41;
      n = 3'(i * 3 + 1);
      w = i[1];
      if (i < 4) begin
        pc = c;
        req <= '{1'b1, {19'h0, c, n, 2'b00}, w, sel};
        if (sel) last = {w ? 14'h2AAA : 14'h0155, c, 5'h00, c[0] ^ w, 3'h0, c[1]};
        else last = {c, w ? 8'h0B : 8'h0A, 8'(n), ~c};
      end
      else req.valid <= 1'b0;
    end
  endtask : t_read
  // one special register read, answer seen one cycle after the request
  task automatic t_spr(input logic [9:0] num, input logic priv, input logic [1:0] eaf, input logic [31:0] ed);
    @(negedge i_ref_clk);
    special_purpose_register <= '{1'b1, num, priv};
    @(negedge i_ref_clk);
    special_purpose_register.valid <= 1'b0;
    check({30'h0, ack, flt}, {30'h0, eaf});
    check(rd, ed);
  endtask : t_spr
  // mid-run reset clears the debug data and the register port
  task automatic t_reset();
    @(negedge i_ref_clk);
    i_rst_b <= 1'h0;
    @(negedge i_ref_clk);
    check(dbg, ICD_DATA_RESET);
    check({29'h0, ack, flt, |rd}, 32'h0000_0000);
    i_rst_b <= 1'h1;
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_ref_clk);
    check(dbg, ICD_DATA_RESET);
    @(negedge i_ref_clk);
    i_rst_b <= 1'b1;
    t_read(ICD_SEL_WORD);
    t_read(1'b1);
    t_spr(ICD_SPR_DEBUG_DATA, 1'b1, 2'b10, last);
    t_spr(10'h3D2, 1'b1, 2'b00, 32'h0000_0000);
    t_spr(ICD_SPR_DEBUG_DATA, 1'b0, 2'b01, 32'h0000_0000);
    t_reset();
    t_spr(ICD_SPR_DEBUG_DATA, 1'h1, 2'h2, ICD_DATA_RESET);
    t_read(ICD_SEL_WORD);
    give_verdict();
  end
  // watchdog against a hung run
  initial begin
    repeat (1000) @(posedge i_ref_clk);
    fails++;
    give_verdict();
  end
endmodule : tb_icd_readout
`default_nettype wire
